// >>> verilog/cvr_pkg.sv
// shared constants, register indices and carriers of the cursor/vertical block
package cvr_pkg;

  // register indices on the indexed data port
  localparam logic [7:0] IDX_MAX_SCAN_LINE  = 8'h09;
  localparam logic [7:0] IDX_CURSOR_START   = 8'h0a;
  localparam logic [7:0] IDX_CURSOR_END     = 8'h0b;
  localparam logic [7:0] IDX_START_ADDR_HI  = 8'h0c;
  localparam logic [7:0] IDX_START_ADDR_LO  = 8'h0d;
  localparam logic [7:0] IDX_CURSOR_LOC_HI  = 8'h0e;
  localparam logic [7:0] IDX_CURSOR_LOC_LO  = 8'h0f;
  localparam logic [7:0] IDX_VSYNC_START_LO = 8'h10;
  localparam int         NUM_REGS           = 8;

  // reset values; max_scan_line has its own constant, also zero, and the rest take zero
  localparam logic [7:0] RST_MAX_SCAN_LINE  = 8'h00;
  localparam logic [7:0] RST_OTHER          = 8'h00;

  // max_scan_line fields
  localparam int MSL_DSCAN_BIT = 7;
  localparam int MSL_LCMP9_BIT = 6;
  localparam int MSL_VBS9_BIT  = 5;
  // timing_overflow_bits fields
  localparam int OVF_VSS9_BIT  = 7;
  localparam int OVF_LCMP8_BIT = 4;
  localparam int OVF_VBS8_BIT  = 3;
  localparam int OVF_VSS8_BIT  = 2;
  // cursor_start / cursor_end fields
  localparam int CST_OFF_BIT   = 5;
  localparam int CEN_SKEW_LSB  = 5;
  localparam int FLD5_MSB      = 4;

  // read masks clear reserved bits
  localparam logic [7:0] CURSOR_START_MASK = 8'h3f;
  localparam logic [7:0] CURSOR_END_MASK   = 8'h7f;

  localparam int SKEW_MAX = 3;

  typedef struct packed {
    logic [7:0] index;
    logic       we;
    logic [7:0] wdata;
  } cvr_wr_s;

  typedef struct packed {
    logic        dscan;
    logic        lcmp9;
    logic        vbs9;
    logic [4:0]  row_max;
    logic        cur_off;
    logic [4:0]  cur_start;
    logic [1:0]  skew;
    logic [4:0]  cur_end;
    logic [15:0] start_addr;
    logic [15:0] cur_loc;
    logic [7:0]  vss_low;
  } cvr_ctrl_s;

endpackage : cvr_pkg

// >>> verilog/cvr_regs.sv
// indexed byte register file and field decode
`timescale 1ns/1ps
module cvr_regs (
  input  wire logic           CLK_SYS,
  input  wire logic           SYS_RST,
  input  wire cvr_pkg::cvr_wr_s WR,
  output logic [7:0]          RDATA,
  output cvr_pkg::cvr_ctrl_s  CTRL
);

  logic [7:0] regs_q [cvr_pkg::NUM_REGS];

  // index decode, shared by write and read paths
  function automatic logic in_map(input logic [7:0] idx);
    in_map = (idx >= cvr_pkg::IDX_MAX_SCAN_LINE) &&
             (idx <= cvr_pkg::IDX_VSYNC_START_LO);
  endfunction : in_map

  function automatic logic [2:0] slot(input logic [7:0] idx);
    logic [7:0] d;
    d    = idx - cvr_pkg::IDX_MAX_SCAN_LINE;
    slot = d[2:0];
  endfunction : slot

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      regs_q[0] <= cvr_pkg::RST_MAX_SCAN_LINE;
      for (int i = 1; i < cvr_pkg::NUM_REGS; i++) begin
        regs_q[i] <= cvr_pkg::RST_OTHER;
      end
    end else if (WR.we && in_map(WR.index)) begin
      regs_q[slot(WR.index)] <= WR.wdata;
    end
  end

  // registered read; reserved bits forced low, unmapped reads zero
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      RDATA <= 8'h00;
    end else if (!in_map(WR.index)) begin
      RDATA <= 8'h00;
    end else if (WR.index == cvr_pkg::IDX_CURSOR_START) begin
      RDATA <= regs_q[slot(WR.index)] & cvr_pkg::CURSOR_START_MASK;
    end else if (WR.index == cvr_pkg::IDX_CURSOR_END) begin
      RDATA <= regs_q[slot(WR.index)] & cvr_pkg::CURSOR_END_MASK;
    end else begin
      RDATA <= regs_q[slot(WR.index)];
    end
  end

  always_comb begin
    CTRL.dscan      = regs_q[0][cvr_pkg::MSL_DSCAN_BIT];
    CTRL.lcmp9      = regs_q[0][cvr_pkg::MSL_LCMP9_BIT];
    CTRL.vbs9       = regs_q[0][cvr_pkg::MSL_VBS9_BIT];
    CTRL.row_max    = regs_q[0][cvr_pkg::FLD5_MSB:0];
    CTRL.cur_off    = regs_q[1][cvr_pkg::CST_OFF_BIT];
    CTRL.cur_start  = regs_q[1][cvr_pkg::FLD5_MSB:0];
    CTRL.skew       = regs_q[2][cvr_pkg::CEN_SKEW_LSB +: 2];
    CTRL.cur_end    = regs_q[2][cvr_pkg::FLD5_MSB:0];
    CTRL.start_addr = {regs_q[3], regs_q[4]};
    CTRL.cur_loc    = {regs_q[5], regs_q[6]};
    CTRL.vss_low    = regs_q[7];
  end

  a_rsvd_read_zero: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    ($past(WR.index) == cvr_pkg::IDX_CURSOR_START) |->
      (RDATA[7:6] == 2'b00 && RDATA[5:0] == $past(regs_q[1][5:0])))
    else $error("cursor_start reserved bits not zero");

endmodule : cvr_regs

// >>> verilog/cvr_skew.sv
// cursor skew delay line in character clocks
`timescale 1ns/1ps
module cvr_skew (
  input  wire logic       CLK_SYS,
  input  wire logic       SYS_RST,
  input  wire logic       CHAR_EN,
  input  wire logic [1:0] SKEW,
  input  wire logic       CUR_IN,
  output logic            CUR_OUT
);

  logic [cvr_pkg::SKEW_MAX:0] stage_q;

  // stage 0 is the undelayed sample; stage k is k character clocks late
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      stage_q <= '0;
    end else if (CHAR_EN) begin
      stage_q <= {stage_q[cvr_pkg::SKEW_MAX-1:0], CUR_IN};
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      CUR_OUT <= 1'b0;
    end else begin
      CUR_OUT <= stage_q[SKEW];
    end
  end

  a_skew_delay: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CHAR_EN && SKEW == 2'b00) |=> ##1 (CUR_OUT == $past(CUR_IN, 2)))
    else $error("zero skew cursor not one sample late");

endmodule : cvr_skew

// >>> verilog/cvr_top.sv
// vertical timing, split screen and text cursor of the crt controller
`timescale 1ns/1ps
// How it works
// - double scan halves row counter rate
// - line compare from three registers
// - compare line restarts address at zero
// - above split start address, below offset zero
// - vertical blank start from three registers
// - row counter wraps at programmed height
// - cursor off bit suppresses cursor
// - cursor only in text modes
// - cursor start line from cursor_start
// - cursor end line from cursor_end
// - skew delays cursor zero to three
// - start address from high and low
// - cursor location from high and low
// - vertical sync start from two registers
// - reserved cursor bits read zero
module cvr_top (
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  REG_INDEX,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  input  wire logic [7:0]  TIMING_OVERFLOW_BITS,
  input  wire logic [7:0]  LINE_COMPARE_LOW,
  input  wire logic [7:0]  VBLANK_START_LOW,
  input  wire logic [15:0] ROW_PITCH,
  input  wire logic        GRAPHICS_MODE,
  input  wire logic        FRAME_START,
  input  wire logic        HSCAN_EN,
  input  wire logic        CHAR_CLK_EN,
  input  wire logic        H_ACTIVE,
  input  wire logic        V_ACTIVE,
  output logic      [15:0] FETCH_ADDR,
  output logic      [4:0]  ROW_SCAN,
  output logic      [9:0]  SCAN_LINE,
  output logic             VBLANK_START,
  output logic             VSYNC_START,
  output logic             CURSOR_PIX
);

  cvr_pkg::cvr_wr_s   wr;
  cvr_pkg::cvr_ctrl_s ctrl;

  logic [9:0]  lcmp;
  logic [9:0]  vbs;
  logic [9:0]  vss;
  logic        line_start;
  logic [9:0]  new_line;
  logic        split_hit;
  logic        row_adv;
  logic        row_wrap;

  logic [9:0]  line_q;
  logic [4:0]  row_q;
  logic [4:0]  row_d;
  logic        half_q;
  logic [15:0] row_base_q;
  logic [15:0] row_base_d;
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic        vblank_q;
  logic        vsync_q;
  logic        cur_raw;

  assign wr.index = REG_INDEX;
  assign wr.we    = REG_WR;
  assign wr.wdata = REG_WDATA;

  cvr_regs u_regs (
    .CLK_SYS (CLK_SYS),
    .SYS_RST (SYS_RST),
    .WR      (wr),
    .RDATA   (REG_RDATA),
    .CTRL    (ctrl)
  );

  // 10-bit vertical values assembled from their scattered bits
  assign lcmp = {ctrl.lcmp9, TIMING_OVERFLOW_BITS[cvr_pkg::OVF_LCMP8_BIT],
                 LINE_COMPARE_LOW};
  assign vbs  = {ctrl.vbs9, TIMING_OVERFLOW_BITS[cvr_pkg::OVF_VBS8_BIT],
                 VBLANK_START_LOW};
  assign vss  = {TIMING_OVERFLOW_BITS[cvr_pkg::OVF_VSS9_BIT],
                 TIMING_OVERFLOW_BITS[cvr_pkg::OVF_VSS8_BIT],
                 ctrl.vss_low};

  // frame start wins over a coincident line pulse; line 0 is first active
  assign line_start = FRAME_START | HSCAN_EN;
  assign new_line   = FRAME_START ? 10'h000 : line_q + 10'h001;
  assign split_hit  = line_start && V_ACTIVE && (new_line == lcmp);

  // with double scan the counter moves on every second line only
  assign row_adv  = !ctrl.dscan || half_q;
  assign row_wrap = row_adv && (row_q == ctrl.row_max);

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      line_q <= 10'h000;
    end else if (line_start) begin
      line_q <= new_line;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      half_q <= 1'b0;
    end else if (FRAME_START) begin
      half_q <= 1'b0;
    end else if (HSCAN_EN) begin
      half_q <= ctrl.dscan ? ~half_q : 1'b0;
    end
  end

  always_comb begin
    row_d      = row_q;
    row_base_d = row_base_q;
    if (FRAME_START) begin
      row_d      = 5'h00;
      row_base_d = ctrl.start_addr;
    end else if (HSCAN_EN) begin
      if (row_wrap) begin
        row_d      = 5'h00;
        row_base_d = row_base_q + ROW_PITCH;
      end else if (row_adv) begin
        row_d = row_q + 5'h01;
      end
    end
    // split line fetches from offset zero; later rows step on from there by row pitch
    if (split_hit) begin
      row_d      = 5'h00;
      row_base_d = 16'h0000;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      row_q      <= 5'h00;
      row_base_q <= 16'h0000;
    end else begin
      row_q      <= row_d;
      row_base_q <= row_base_d;
    end
  end

  // memory address counter: reload at each line, step per character
  always_comb begin
    addr_d = addr_q;
    if (line_start) begin
      addr_d = row_base_d;
    end else if (CHAR_CLK_EN && H_ACTIVE) begin
      addr_d = addr_q + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      addr_q <= 16'h0000;
    end else begin
      addr_q <= addr_d;
    end
  end

  // one-cycle markers for the blank and sync generators downstream
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      vblank_q <= 1'b0;
      vsync_q  <= 1'b0;
    end else begin
      vblank_q <= line_start && (new_line == vbs);
      vsync_q  <= line_start && (new_line == vss);
    end
  end

  // cursor term sampled per character; skew stage realigns it
  always_comb begin
    cur_raw = !GRAPHICS_MODE && !ctrl.cur_off
              && H_ACTIVE && V_ACTIVE
              && (addr_q == ctrl.cur_loc)
              && (row_q >= ctrl.cur_start)
              && (row_q <= ctrl.cur_end);
  end

  cvr_skew u_skew (
    .CLK_SYS (CLK_SYS),
    .SYS_RST (SYS_RST),
    .CHAR_EN (CHAR_CLK_EN),
    .SKEW    (ctrl.skew),
    .CUR_IN  (cur_raw),
    .CUR_OUT (CURSOR_PIX)
  );

  assign FETCH_ADDR   = addr_q;
  assign ROW_SCAN     = row_q;
  assign SCAN_LINE    = line_q;
  assign VBLANK_START = vblank_q;
  assign VSYNC_START  = vsync_q;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  a_dscan_hold: assert property (
    (HSCAN_EN && !FRAME_START && !split_hit && ctrl.dscan && !half_q) |=>
      (row_q == $past(row_q) && half_q))
    else $error("double scan advanced on first line of pair");

  a_row_step: assert property (
    (HSCAN_EN && !FRAME_START && !split_hit && !ctrl.dscan &&
     row_q != ctrl.row_max) |=> (row_q == $past(row_q) + 5'h01))
    else $error("row counter did not step");

  a_row_wrap: assert property (
    (HSCAN_EN && !FRAME_START && !split_hit && row_wrap) |=>
      (row_q == 5'h00 && row_base_q == $past(row_base_q + ROW_PITCH)))
    else $error("row counter did not wrap at height");

  a_split_restart: assert property (
    (line_start && V_ACTIVE &&
     new_line == {ctrl.lcmp9, TIMING_OVERFLOW_BITS[4], LINE_COMPARE_LOW})
      |=> (FETCH_ADDR == 16'h0000 && ROW_SCAN == 5'h00))
    else $error("split line did not restart at zero");

  a_top_start: assert property (
    (FRAME_START && !split_hit) |=>
      (FETCH_ADDR == $past(ctrl.start_addr)))
    else $error("frame did not fetch from start address");

  a_vblank_mark: assert property (
    (line_start && new_line == vbs) |=> VBLANK_START ##1
      (!VBLANK_START || line_start))
    else $error("vertical blank start marker wrong");

  a_vsync_mark: assert property (
    (VSYNC_START) |-> ($past(line_start) && SCAN_LINE == vss))
    else $error("vertical sync start marker without match");

  a_cursor_gfx: assert property (
    (GRAPHICS_MODE || ctrl.cur_off) [*6] |-> !CURSOR_PIX)
    else $error("cursor drawn in graphics mode or while off");

  a_cursor_loc: assert property (
    (CHAR_CLK_EN && ctrl.skew == 2'b00 && cur_raw) |=> ##1 CURSOR_PIX)
    else $error("cursor not shown at matching address");

  c_split: cover property (split_hit && line_q != 10'h000);
  c_cursor: cover property (CURSOR_PIX && ctrl.skew == 2'b11);
  c_dscan_wrap: cover property (HSCAN_EN && ctrl.dscan && row_wrap);
  c_vsync: cover property (VSYNC_START);

endmodule : cvr_top

// >>> tb/cvr_timing_model.sv
// raster timing source standing in for the rest of the crt controller
`timescale 1ns/1ps
module cvr_timing_model #(
  parameter int LINE_LEN    = 24,
  parameter int ACT_CHARS   = 12,
  parameter int FRAME_LINES = 20,
  parameter int ACT_LINES   = 16
) (
  input  wire logic CLK_SYS,
  input  wire logic SYS_RST,
  input  wire logic START,
  output logic      BUSY,
  output logic      FRAME_START,
  output logic      HSCAN_EN,
  output logic      CHAR_CLK_EN,
  output logic      H_ACTIVE,
  output logic      V_ACTIVE
);
  int pos_q;
  int line_q;
  int pos_d;

  assign pos_d = (pos_q == LINE_LEN - 1) ? 0 : pos_q + 1;

  // one frame per start request; everything idles low between frames
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      {BUSY, FRAME_START, HSCAN_EN, CHAR_CLK_EN, H_ACTIVE, V_ACTIVE} <= '0;
      pos_q <= 0;
      line_q <= 0;
    end else if (START && !BUSY) begin
      // frame begins on the first active line, numbered zero
      {BUSY, FRAME_START, CHAR_CLK_EN, V_ACTIVE} <= 4'hf;
      pos_q <= 0;
      line_q <= 0;
    end else if (BUSY) begin
      FRAME_START <= 1'b0;
      pos_q <= pos_d;
      HSCAN_EN <= (pos_d == 0) && (line_q + 1 < FRAME_LINES);
      H_ACTIVE <= (pos_d >= 1) && (pos_d <= ACT_CHARS);
      if (pos_d == 0) begin
        line_q <= line_q + 1;
        V_ACTIVE <= (line_q + 1 < ACT_LINES);
        if (line_q + 1 == FRAME_LINES) begin
          {BUSY, CHAR_CLK_EN, H_ACTIVE, V_ACTIVE} <= '0;
        end
      end
    end
  end
endmodule : cvr_timing_model

// >>> tb/tb.sv
// self-checking bench of the cursor and vertical timing block
`timescale 1ns/1ps
module tb;
  localparam int AC = 12;
  localparam int AL = 16;
  logic        clk, rst, reg_wr, gfx, start, busy, fs, hs, ce_en;
  logic        hact, vact, vb, vs, cpix;
  logic [7:0]  reg_index, reg_wdata, reg_rdata, ovf, lcl, vbl;
  logic [15:0] pitch, fetch;
  logic [4:0]  row;
  logic [9:0]  sline;
  logic [7:0]  shadow [0:7];
  logic [31:0] seed, r, cur_exp, e;
  logic [15:0] d;
  logic        pend;
  int          n_mismatch, n_compared, cyc, line, t0, n_on, first_on;
  logic        dscan, coff;
  logic [4:0]  rmax, cs, cend;
  logic [1:0]  skew;
  logic [9:0]  lc, vbs, vss;
  logic [15:0] sa, cl;

  assign dscan = shadow[0][7];
  assign rmax  = shadow[0][4:0];
  assign lc    = {shadow[0][6], ovf[4], lcl};
  assign vbs   = {shadow[0][5], ovf[3], vbl};
  assign vss   = {ovf[7], ovf[2], shadow[7]};
  assign sa    = {shadow[3], shadow[4]};
  assign cl    = {shadow[5], shadow[6]};
  assign coff  = shadow[1][5];
  assign cs    = shadow[1][4:0];
  assign cend  = shadow[2][4:0];
  assign skew  = shadow[2][6:5];

  cvr_top u_dut (
    .CLK_SYS(clk), .SYS_RST(rst), .REG_INDEX(reg_index), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .TIMING_OVERFLOW_BITS(ovf),
    .LINE_COMPARE_LOW(lcl), .VBLANK_START_LOW(vbl), .ROW_PITCH(pitch),
    .GRAPHICS_MODE(gfx), .FRAME_START(fs), .HSCAN_EN(hs),
    .CHAR_CLK_EN(ce_en), .H_ACTIVE(hact), .V_ACTIVE(vact),
    .FETCH_ADDR(fetch), .ROW_SCAN(row), .SCAN_LINE(sline),
    .VBLANK_START(vb), .VSYNC_START(vs), .CURSOR_PIX(cpix));

  cvr_timing_model u_tim (
    .CLK_SYS(clk), .SYS_RST(rst), .START(start), .BUSY(busy),
    .FRAME_START(fs), .HSCAN_EN(hs), .CHAR_CLK_EN(ce_en),
    .H_ACTIVE(hact), .V_ACTIVE(vact));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // base, row and line number expected on line l of a frame
  function automatic logic [31:0] exp_line(input int l);
    int          n;
    logic [15:0] b;
    b = sa;
    n = l;
    if (lc < AL && l >= lc) begin
      b = 16'h0000;
      n = l - lc;
    end
    if (dscan) n = n / 2;
    b = b + 16'(n / (rmax + 1)) * pitch;
    return {b, 1'b0, 5'(n % (rmax + 1)), 10'(l)};
  endfunction : exp_line

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    @(posedge clk);
    reg_index <= idx;
    reg_wr <= 1'b1;
    reg_wdata <= dat;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (idx >= 8'h09 && idx <= 8'h10) shadow[idx - 8'h09] = dat;
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx);
    logic [7:0] x;
    x = 8'h00;
    if (idx >= 8'h09 && idx <= 8'h10) x = shadow[idx - 8'h09];
    if (idx == 8'h0a) x = x & 8'h3f;
    if (idx == 8'h0b) x = x & 8'h7f;
    @(posedge clk);
    reg_index <= idx;
    repeat (2) @(posedge clk);
    #1;
    chk8(reg_rdata, x);
  endtask : rd_chk

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // line-start monitor; cursor result of a line is judged at the next start
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      test_done();
    end
    if (fs || hs) begin
      if (pend) chk32({n_on[15:0], first_on[15:0]}, cur_exp);
      line = fs ? 0 : line + 1;
      t0 = cyc;
      n_on = 0;
      first_on = 0;
      #1;
      e = exp_line(line);
      chk32({20'h0, vb, vs, sline}, {20'h0, sline == vbs, sline == vss, e[9:0]});
      if (line < AL) chk32({fetch, 1'b0, row, sline}, e);
      d = cl - e[31:16];
      cur_exp = 32'h0;
      if (!gfx && !coff && line < AL && e[14:10] >= cs && e[14:10] <= cend
          && d < AC) cur_exp = {16'd1, d + 16'd2 + 16'(skew)};
      pend = 1'b1;
    end else begin
      #1;
      if (cpix) begin
        if (n_on == 0) first_on = cyc - t0;
        n_on++;
      end
    end
  end

  initial begin
    {rst, reg_wr, gfx, start, pend} = 5'b10000;
    {reg_index, reg_wdata, ovf, lcl, vbl} = '0;
    pitch = 16'h0;
    seed = 32'hf95d8845;
    {n_mismatch, n_compared, cyc, line, t0, n_on, first_on} = '0;
    for (int i = 0; i < 8; i++) shadow[i] = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 8; i <= 17; i++) rd_chk(i[7:0]);
    $display("test reset_values done");
    wr(8'h11, 8'hff);
    wr(8'h08, 8'h5a);
    wr(8'h0a, 8'hff);
    wr(8'h0b, 8'hff);
    for (int k = 0; k < 4; k++) begin
      for (int i = 8; i <= 17; i++) begin
        r = rnd();
        wr(i[7:0], r[7:0]);
      end
      for (int i = 8; i <= 17; i++) rd_chk(i[7:0]);
    end
    $display("test register_access done");
    for (int f = 0; f < 12; f++) begin
      r = rnd();
      // dscan frames keep the split off, others split or sit off-screen
      wr(8'h09, {f % 3 == 1, f % 3 == 1, r[5], 3'b000, r[7:6]});
      ovf = r[31:24];
      ovf[4] = (f % 3 == 2);
      lcl = (f == 0) ? 8'h00 : {4'h0, r[3:0]};
      vbl = {3'h0, r[12:8]};
      pitch = {4'h0, r[27:16]} | 16'h0020;
      wr(8'h0c, (f == 4) ? 8'hff : r[15:8]);
      wr(8'h0d, (f == 4) ? 8'hff : r[23:16]);
      wr(8'h10, {3'h0, r[20:16]});
      r = rnd();
      wr(8'h0a, {r[1:0], f == 7, 3'b000, r[9:8] & shadow[0][1:0]});
      wr(8'h0b, {r[2], f[1:0], shadow[0][4:0]});
      gfx = (f == 9) || (f == 10);
      {shadow[5], shadow[6]} = sa + 16'(r[4]) * pitch + 16'(r[31:24] % AC);
      wr(8'h0e, shadow[5]);
      wr(8'h0f, shadow[6]);
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
      $display("test frame %0d done", f);
    end
    test_done();
  end
endmodule : tb
